// *** hdl/dual_counter_block.v ***
// Dual counter block: up/down or quadrature counter with reference clear/latch,
// and a pulse-width meter, reached over a plain register port.
// Assumes all pins are driven by external logic and may be asynchronous;
// each pin is synchronised inside before use.
// Read data stand for one cycle after the read strobe and read as zero otherwise.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "dual_counter_consts.vh"
module dual_counter_block #(
  parameter W = `CNT_W
) (
  input  wire               clk,
  input  wire               reset_n,
  input  wire [`ADDR_W-1:0] addr,
  input  wire [31:0]        wr_data,
  input  wire               wr_stb,
  input  wire               rd_stb,
  output reg  [31:0]        rd_data_ff,
  input  wire               count_pulse_in,
  input  wire               direction_in,
  input  wire               phase_a_in,
  input  wire               phase_b_in,
  input  wire               ref_capture_in,
  input  wire               pulse_in,
  output reg  [W-1:0]       count_out_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  wire cp_level;
  wire cp_prev;
  wire cp_rise;
  wire cp_fall;
  wire dir_level;
  wire a_level;
  wire a_prev;
  wire b_level;
  wire b_prev;
  wire ref_level;
  wire ref_rise;
  wire pw_level;
  wire pw_rise;

  edge_sync u_sync_cp (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (count_pulse_in),
    .level   (cp_level),
    .prev    (cp_prev),
    .rise    (cp_rise),
    .fall    (cp_fall)
  );

  edge_sync u_sync_dir (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (direction_in),
    .level   (dir_level),
    .prev    (),
    .rise    (),
    .fall    ()
  );

  edge_sync u_sync_a (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (phase_a_in),
    .level   (a_level),
    .prev    (a_prev),
    .rise    (),
    .fall    ()
  );

  edge_sync u_sync_b (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (phase_b_in),
    .level   (b_level),
    .prev    (b_prev),
    .rise    (),
    .fall    ()
  );

  edge_sync u_sync_ref (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (ref_capture_in),
    .level   (ref_level),
    .prev    (),
    .rise    (ref_rise),
    .fall    ()
  );

  edge_sync u_sync_pw (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (pulse_in),
    .level   (pw_level),
    .prev    (),
    .rise    (pw_rise),
    .fall    ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Control registers and command decode

  reg  [`CTRL_W-1:0] ctrl_ff;
  reg                latch_new_ff;
  reg  [W-1:0]       latch_ff;

  wire wr_ctrl = wr_stb & (addr == `ADR_CTRL);
  wire wr_cmd  = wr_stb & (addr == `ADR_CMD);
  wire rd_latch = rd_stb & (addr == `ADR_LATCH);

  reg  [`CTRL_W-1:0] nxt_ctrl;
  reg                soft_snap;
  reg                soft_zero;

  // Command bits are one-cycle pulses and are never stored
  always @* begin
    soft_snap = 1'b0;
    soft_zero = 1'b0;
    if (wr_cmd) begin
      soft_snap = wr_data[`CMD_SNAP];
      soft_zero = wr_data[`CMD_ZERO];
    end
  end

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
      nxt_ctrl = wr_data[`CTRL_W-1:0];
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl_ff <= `CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  wire ud_en       = ctrl_ff[`CTRL_UD_EN];
  wire quad_mode   = ctrl_ff[`CTRL_QUAD];
  wire ref_zero_enable     = ctrl_ff[`CTRL_ZERO_EN];
  wire ref_snapshot_enable = ctrl_ff[`CTRL_SNAP_EN];
  wire ref_only    = ctrl_ff[`CTRL_REF_ONLY];
  wire pw_en       = ctrl_ff[`CTRL_PW_EN];

  ////////////////////////////////////////////////////////////////////////
  // Step generation for both modes

  reg step;
  reg step_up;
  reg a_chg;
  reg b_chg;

  always @* begin
    step    = 1'b0;
    step_up = 1'b0;
    a_chg   = a_level ^ a_prev;
    b_chg   = b_level ^ b_prev;
    if (ud_en) begin
      if (quad_mode) begin
        // One phase changing alone is a valid step; both at once is ignored
        step    = a_chg ^ b_chg;
        step_up = a_level ^ b_prev;
      end else begin
        step    = cp_fall;
        step_up = dir_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference input actions

  reg ref_zero;
  reg ref_snap;

  always @* begin
    ref_zero = 1'b0;
    ref_snap = 1'b0;
    if (ud_en) begin
      ref_snap = ref_snapshot_enable & ref_rise;
      // Quadrature clear is a level and holds the count at zero while A and B are both high, or at any phase with ref_only
      if (quad_mode) begin
        if (ref_only)
          ref_zero = ref_zero_enable & ref_level;
        else
          ref_zero = ref_zero_enable & ref_level & a_level & b_level;
      end else begin
        ref_zero = ref_zero_enable & ref_rise;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Up/down counter and latch

  reg  [W-1:0] nxt_count;
  reg  [W-1:0] nxt_latch;
  reg          nxt_latch_new;
  wire [W-1:0] one_w    = {{(W-1){1'b0}}, 1'b1};
  wire         do_snap  = soft_snap | ref_snap;
  wire         zero_now = soft_zero | ref_zero;
  wire         step_inc = step & step_up;
  wire         step_dec = step & ~step_up;

  // A clear beats a step that falls in the same cycle
  always @* begin
    nxt_count = count_out_ff;
    if (zero_now)
      nxt_count = {W{1'b0}};
    else if (step_inc)
      nxt_count = count_out_ff + one_w;
    else if (step_dec)
      nxt_count = count_out_ff - one_w;
  end

  always @* begin
    nxt_latch     = latch_ff;
    nxt_latch_new = latch_new_ff;
    if (do_snap)
      nxt_latch = count_out_ff;
    // A new capture wins over the clear by reading
    if (do_snap)
      nxt_latch_new = 1'b1;
    else if (rd_latch)
      nxt_latch_new = 1'b0;
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      count_out_ff <= {W{1'b0}};
      latch_ff     <= {W{1'b0}};
      latch_new_ff <= 1'b0;
    end else begin
      count_out_ff <= nxt_count;
      latch_ff     <= nxt_latch;
      latch_new_ff <= nxt_latch_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse-width meter

  wire [W-1:0] pw_high;
  wire [W-1:0] pw_low;
  wire [W-1:0] pw_period;
  wire         pw_valid;

  pulse_width_meter #(
    .W (W)
  ) u_pwm (
    .clk       (clk),
    .reset_n   (reset_n),
    .enable    (pw_en),
    .level     (pw_level),
    .rise      (pw_rise),
    .high_ff   (pw_high),
    .low_ff    (pw_low),
    .period_ff (pw_period),
    .valid_ff  (pw_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read path: data stand only in the cycle after the strobe

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = `ZERO32;
    case (addr)
      `ADR_CTRL:   rd_mux[`CTRL_W-1:0] = ctrl_ff;
      `ADR_COUNT:  rd_mux[W-1:0] = count_out_ff;
      `ADR_LATCH:  rd_mux[W-1:0] = latch_ff;
      `ADR_HIGH:   rd_mux[W-1:0] = pw_high;
      `ADR_LOW:    rd_mux[W-1:0] = pw_low;
      `ADR_PERIOD: rd_mux[W-1:0] = pw_period;
      `ADR_STATUS: begin
        rd_mux[`STAT_LATCH_NEW] = latch_new_ff;
        rd_mux[`STAT_PW_VALID]  = pw_valid;
      end
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  reg [31:0] nxt_rd_data;

  always @* begin
    nxt_rd_data = `ZERO32;
    if (rd_stb)
      nxt_rd_data = rd_mux;
  end

  always @(posedge clk) begin
    if (!reset_n)
      rd_data_ff <= `ZERO32;
    else
      rd_data_ff <= nxt_rd_data;
  end

endmodule // dual_counter_block

// *** hdl/dual_counter_consts.vh ***
// Constants of the dual counter block: register map, control fields, reset values.
// Assumes inclusion by bare name from the counter block and pulse-width meter design files.
`ifndef DUAL_COUNTER_CONSTS_VH
`define DUAL_COUNTER_CONSTS_VH

`define CNT_W          32
`define ADDR_W         8

// Register byte addresses
`define ADR_CTRL       8'h00
`define ADR_CMD        8'h04
`define ADR_COUNT      8'h08
`define ADR_LATCH      8'h0C
`define ADR_HIGH       8'h10
`define ADR_LOW        8'h14
`define ADR_PERIOD     8'h18
`define ADR_STATUS     8'h1C

// Control register fields
`define CTRL_W         6
`define CTRL_RST       6'h00
`define CTRL_UD_EN     0
`define CTRL_QUAD      1
`define CTRL_ZERO_EN   2
`define CTRL_SNAP_EN   3
`define CTRL_REF_ONLY  4
`define CTRL_PW_EN     5

// Command register fields, write-only pulses
`define CMD_SNAP       0
`define CMD_ZERO       1

// Status register fields
`define STAT_LATCH_NEW 0
`define STAT_PW_VALID  1

`define ZERO32         32'h0000_0000
`define ONE32          32'h0000_0001

`endif

// *** hdl/edge_sync.v ***
// Two-flop synchroniser with a third stage for edge detection.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module edge_sync (
  input  wire clk,
  input  wire reset_n,
  input  wire din,
  output wire level,
  output wire prev,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  reg hist_ff;

  always @(posedge clk) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      hist_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign prev  = hist_ff;
  assign rise  = sync_ff & ~hist_ff;
  assign fall  = ~sync_ff & hist_ff;
endmodule // edge_sync

// *** hdl/pulse_width_meter.v ***
// Pulse-width meter: high, low and period times in clock cycles.
// Assumes a synchronised input level with its rising edge pulse.
`timescale 1ns/10ps
`include "dual_counter_consts.vh"
module pulse_width_meter #(
  parameter W = `CNT_W
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         enable,
  input  wire         level,
  input  wire         rise,
  output reg  [W-1:0] high_ff,
  output reg  [W-1:0] low_ff,
  output reg  [W-1:0] period_ff,
  output reg          valid_ff
);
  reg  [W-1:0] hcnt_ff;
  reg  [W-1:0] lcnt_ff;
  reg          armed_ff;
  wire [W-1:0] all_ones = {W{1'b1}};

  always @(posedge clk) begin
    if (!reset_n || !enable) begin
      hcnt_ff   <= {W{1'b0}};
      lcnt_ff   <= {W{1'b0}};
      armed_ff  <= 1'b0;
      high_ff   <= {W{1'b0}};
      low_ff    <= {W{1'b0}};
      period_ff <= {W{1'b0}};
      valid_ff  <= 1'b0;
    end else if (rise) begin
      // Each rising edge but the first after enable closes one full period
      if (armed_ff) begin
        high_ff   <= hcnt_ff;
        low_ff    <= lcnt_ff;
        period_ff <= hcnt_ff + lcnt_ff;
        valid_ff  <= 1'b1;
      end
      armed_ff <= 1'b1;
      hcnt_ff  <= {{(W-1){1'b0}}, 1'b1};
      lcnt_ff  <= {W{1'b0}};
    end else if (level) begin
      if (hcnt_ff != all_ones)
        hcnt_ff <= hcnt_ff + {{(W-1){1'b0}}, 1'b1};
    end else begin
      if (lcnt_ff != all_ones)
        lcnt_ff <= lcnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // pulse_width_meter

// *** dv/dual_counter_chk.sv ***
// Port checker of the dual counter block.
// Assumes a bind onto every instance of the block.
`timescale 1ns/10ps
module dual_counter_chk #(
  parameter W = 32
) (
  input wire         clk,
  input wire         reset_n,
  input wire [7:0]   addr,
  input wire [31:0]  wr_data,
  input wire         wr_stb,
  input wire         rd_stb,
  input wire [31:0]  rd_data_ff,
  input wire         count_pulse_in,
  input wire         direction_in,
  input wire         phase_a_in,
  input wire         phase_b_in,
  input wire         ref_capture_in,
  input wire         pulse_in,
  input wire [W-1:0] count_out_ff
);
  wire [4:0] pins = {count_pulse_in, direction_in, phase_a_in, phase_b_in, ref_capture_in};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_reset_zero: assert property (disable iff (1'b0)
    !reset_n |=> count_out_ff == 0 && rd_data_ff == 32'h0) else $error("not zero after reset");
  chk_count_source: assert property (
    $changed(count_out_ff) |-> $past(pins, 3) != $past(pins, 4) || $past(wr_stb)
    || $past(wr_stb, 2)) else $error("count moved without cause");
  chk_step_size: assert property (
    $changed(count_out_ff) && !$past(wr_stb) |-> count_out_ff == $past(count_out_ff) + 1
    || count_out_ff == $past(count_out_ff) - 1 || count_out_ff == 0)
    else $error("count step not one");
  chk_clkdir_up: assert property (
    $fell(count_pulse_in) && direction_in ##3 $changed(count_out_ff)
    |-> count_out_ff == $past(count_out_ff) + 1 || count_out_ff == 0)
    else $error("count did not go up");
  chk_quad_up: assert property (
    $changed(phase_a_in) && $stable(phase_b_in) && phase_a_in != phase_b_in
    ##3 $changed(count_out_ff) |-> count_out_ff == $past(count_out_ff) + 1
    || count_out_ff == 0) else $error("quadrature step not up");
  chk_read_count: assert property (
    rd_stb && addr == 8'h08 |=> rd_data_ff == $past(count_out_ff))
    else $error("count read wrong");
  chk_read_idle: assert property (
    !rd_stb |=> rd_data_ff == 32'h0) else $error("read data not idle");
  chk_read_unmapped: assert property (
    rd_stb && addr > 8'h1C |=> rd_data_ff == 32'h0) else $error("unmapped read not zero");
endmodule // dual_counter_chk

bind dual_counter_block dual_counter_chk #(.W(W)) dual_counter_chk_i (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data_ff(rd_data_ff), .count_pulse_in(count_pulse_in),
  .direction_in(direction_in), .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
  .ref_capture_in(ref_capture_in), .pulse_in(pulse_in), .count_out_ff(count_out_ff));

// *** dv/enc_model.sv ***
// Encoder and pulse source model driving the counter pins.
// Assumes the bench calls its tasks; every level lasts four clocks, except pw levels, which last h and l clocks.
`timescale 1ns/10ps
module enc_model (
  input  wire clk,
  output reg  count_pulse_in = 1'b1,
  output reg  direction_in   = 1'b1,
  output reg  phase_a_in     = 1'b0,
  output reg  phase_b_in     = 1'b0,
  output reg  ref_capture_in = 1'b0,
  output reg  pulse_in       = 1'b0
);
  task hold;
    repeat (4) @(posedge clk);
  endtask
  task clk_step(input reg d, input integer n);
    repeat (n) begin
      direction_in <= d;
      count_pulse_in <= 1'b0;
      hold;
      count_pulse_in <= 1'b1;
      hold;
    end
  endtask
  // Phases stay 90 degrees apart, one edge at a time
  task quad(input integer n, input reg up);
    repeat (n) begin
      if ((phase_a_in == phase_b_in) == up) phase_a_in <= ~phase_a_in;
      else phase_b_in <= ~phase_b_in;
      hold;
    end
  endtask
  task ref_set(input reg r);
    begin
      ref_capture_in <= r;
      hold;
    end
  endtask
  task ref_pulse;
    begin
      ref_set(1'b1);
      ref_set(1'b0);
    end
  endtask
  task pw(input integer h, input integer l, input integer n);
    repeat (n) begin
      pulse_in <= 1'b1;
      repeat (h) @(posedge clk);
      pulse_in <= 1'b0;
      repeat (l) @(posedge clk);
    end
  endtask
endmodule // enc_model

// *** dv/dual_counter_block_tb.sv ***
// Self-checking bench of the dual counter block.
// Assumes the encoder model and the bound checker.
`timescale 1ns/10ps
module dual_counter_block_tb;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wr_data = 32'h0;
  reg         wr_stb = 1'b0;
  reg         rd_stb = 1'b0;
  wire [31:0] rd_data_ff;
  wire [31:0] count_out_ff;
  wire        cnt_p, dir_p, a_p, b_p, ref_p, pw_p;
  integer     fails = 0;
  integer     check_count = 0;
  reg  [31:0] v;
  reg  [31:0] snap;

  dual_counter_block dual_counter_block_i (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_ff(rd_data_ff), .count_pulse_in(cnt_p),
    .direction_in(dir_p), .phase_a_in(a_p), .phase_b_in(b_p),
    .ref_capture_in(ref_p), .pulse_in(pw_p), .count_out_ff(count_out_ff));
  enc_model enc_model_i (
    .clk(clk), .count_pulse_in(cnt_p), .direction_in(dir_p), .phase_a_in(a_p),
    .phase_b_in(b_p), .ref_capture_in(ref_p), .pulse_in(pw_p));

  initial begin
    forever #4 clk = ~clk;
  end
  task stop_test;
    begin
      if (fails == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      v = rd_data_ff;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(v, e);
    end
  endtask
  task t_clkdir;
    begin
      wr(8'h00, 32'h1);
      enc_model_i.clk_step(1'b1, 3);
      rdc(8'h08, 32'h3);
      enc_model_i.clk_step(1'b0, 5);
      rdc(8'h08, 32'hFFFF_FFFE);
    end
  endtask
  task t_snap;
    begin
      wr(8'h04, 32'h1);
      rdc(8'h1C, 32'h1);
      rdc(8'h0C, 32'hFFFF_FFFE);
      snap = v;
      enc_model_i.clk_step(1'b1, 7);
      wr(8'h04, 32'h1);
      rd(8'h0C);
      chk(v - snap, 32'h7);
    end
  endtask
  task t_ref;
    begin
      enc_model_i.ref_pulse;
      rdc(8'h08, 32'h5);
      rdc(8'h1C, 32'h0);
      wr(8'h00, 32'h9);
      enc_model_i.clk_step(1'b1, 1);
      enc_model_i.ref_pulse;
      rdc(8'h0C, 32'h6);
      wr(8'h00, 32'h5);
      enc_model_i.ref_pulse;
      rdc(8'h08, 32'h0);
      rdc(8'h40, 32'h0);
    end
  endtask
  task t_quad;
    begin
      wr(8'h00, 32'h3);
      enc_model_i.quad(8, 1'b1);
      rdc(8'h08, 32'h8);
      enc_model_i.quad(4, 1'b0);
      rdc(8'h08, 32'h4);
      wr(8'h00, 32'h7);
      enc_model_i.ref_set(1'b1);
      rdc(8'h08, 32'h4);
      enc_model_i.quad(2, 1'b1);
      rdc(8'h08, 32'h0);
      enc_model_i.ref_set(1'b0);
      enc_model_i.quad(2, 1'b1);
      rdc(8'h08, 32'h2);
      wr(8'h00, 32'h17);
      enc_model_i.ref_set(1'b1);
      rdc(8'h08, 32'h0);
      enc_model_i.ref_set(1'b0);
      wr(8'h00, 32'hB);
      enc_model_i.quad(3, 1'b1);
      enc_model_i.ref_pulse;
      rdc(8'h0C, 32'h3);
      wr(8'h04, 32'h2);
      rdc(8'h08, 32'h0);
    end
  endtask
  task t_pw;
    begin
      wr(8'h00, 32'h21);
      fork
        enc_model_i.pw(5, 3, 4);
        enc_model_i.clk_step(1'b1, 3);
      join
      rdc(8'h10, 32'h5);
      rdc(8'h14, 32'h3);
      rdc(8'h18, 32'h8);
      rdc(8'h08, 32'h3);
      rdc(8'h1C, 32'h2);
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails = fails + 1;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdc(8'h00, 32'h0);
    t_clkdir;
    t_snap;
    wr(8'h00, 32'h1);
    t_ref;
    t_quad;
    t_pw;
    stop_test;
  end
endmodule // dual_counter_block_tb
